// >>> pcc_codec.sv
`timescale 1ns/1ps
module pcc_codec (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control pins
  input wire logic law_select_pin,
  input wire logic power_down_input_n,
  input wire logic transmit_frame_sync,
  // linear samples from the converter
  input wire pcc_pkg::pcc_lin_t lin_in,
  output logic lin_in_ready,
  // serial pcm transmit pin
  output logic pcm_transmit_output,
  output logic pcm_transmit_output_oe_n,
  // received codes and expanded samples
  input wire pcc_pkg::pcc_code_t rx_code,
  output pcc_pkg::pcc_lin_t lin_out
);
  import pcc_pkg::*;

  // -------------------------------------------------------------
  // companding functions
  // -------------------------------------------------------------
  // chord search
  function automatic logic [2:0] seg(input logic [7:0] v);
    seg = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (v[i]) begin
        seg = 3'(i);
      end
    end
  endfunction

  function automatic logic [7:0] enc(input logic [12:0] s, input logic mu);
    logic neg;
    logic [12:0] m;
    logic [13:0] b;
    logic [2:0] ch;
    logic [3:0] st;
    neg = s[12];
    // ones complement keeps the most negative value inside 12 bits
    m = neg ? ~s : s;
    if (mu) begin
      b = {m, 1'b0} + MU_BIAS_ENC;
      if (b > MU_CLIP) begin
        b = MU_CLIP;
      end
      ch = seg(b[12:5]);
      st = 4'(b >> ({1'b0, ch} + 4'h1));
      enc = ~{neg, ch, st};
    end else begin
      ch = seg(m[11:4]);
      st = (ch == 3'h0) ? m[4:1] : 4'(m >> ch);
      enc = {~neg, ch, st} ^ ALAW_XOR;
    end
  endfunction

  function automatic logic [12:0] dec(input logic [7:0] c, input logic mu);
    logic [7:0] x;
    logic [2:0] ch;
    logic [3:0] st;
    logic [15:0] t;
    logic [11:0] mag;
    logic neg;
    x = mu ? ~c : c ^ ALAW_XOR;
    ch = x[CHORD_POS +: 3];
    st = x[STEP_POS +: 4];
    if (mu) begin
      neg = x[SIGN_POS];
      t = (({9'h000, st, 3'b000} + MU_BIAS_DEC) << ch) - MU_BIAS_DEC;
      mag = t[14:3];
    end else begin
      neg = ~x[SIGN_POS];
      t = (ch == 3'h0) ? {11'h000, st, 1'b1}
                       : ({10'h000, 1'b1, st, 1'b1} << (ch - 3'h1));
      mag = t[11:0];
    end
    dec = neg ? 13'(~{1'b0, mag} + 13'h0001) : {1'b0, mag};
  endfunction

  // -------------------------------------------------------------
  // encoder into the transmit fifo
  // -------------------------------------------------------------
  logic mu_sel;
  logic [7:0] enc_code;
  logic f_ready, f_ovalid, f_pop;
  logic [7:0] f_odata;

  assign mu_sel = (law_select_pin == LAW_MU);
  assign enc_code = enc(lin_in.sample, mu_sel);

  // back-pressure reaches the sample source through lin_in_ready
  pcc_fifo #(.W(CODE_W), .D(FIFO_D)) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(lin_in.valid),
    .in_data(enc_code),
    .in_ready(f_ready),
    .out_valid(f_ovalid),
    .out_data(f_odata),
    .out_ready(f_pop)
  );
  assign lin_in_ready = f_ready;

  // -------------------------------------------------------------
  // power-up sequencing
  // -------------------------------------------------------------
  pcc_pwr_t pwr_q, pwr_d;
  logic fs_q, fs_d, fs_rise;
  logic [1:0] pu_cnt_q, pu_cnt_d;

  always_comb begin
    fs_d = transmit_frame_sync;
    fs_rise = transmit_frame_sync & ~fs_q;
    pwr_d = pwr_q;
    pu_cnt_d = pu_cnt_q;
    case (pwr_q)
      PCC_DOWN: begin
        pu_cnt_d = 2'h0;
        if (power_down_input_n) begin
          pwr_d = PCC_WAKE;
        end
      end
      PCC_WAKE: begin
        // count three frame syncs before driving
        if (fs_rise) begin
          pu_cnt_d = 2'(pu_cnt_q + 1'b1);
          if (pu_cnt_q == 2'(PU_FRAMES)) begin
            pwr_d = PCC_RUN;
          end
        end
      end
      PCC_RUN: begin
        pwr_d = PCC_RUN;
      end
      default: begin
        pwr_d = PCC_DOWN;
      end
    endcase
    if (!power_down_input_n) begin
      pwr_d = PCC_DOWN;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q <= PCC_DOWN;
      fs_q <= 1'b0;
      pu_cnt_q <= 2'h0;
    end else begin
      pwr_q <= pwr_d;
      fs_q <= fs_d;
      pu_cnt_q <= pu_cnt_d;
    end
  end

  // -------------------------------------------------------------
  // transmit serializer
  // -------------------------------------------------------------
  logic [7:0] sh_q, sh_d;
  logic [3:0] bits_q, bits_d;
  logic [2:0] div_q, div_d;
  logic bit_en;
  logic dt_q, dt_d, oe_n_q, oe_n_d;

  always_comb begin
    bit_en = (div_q == 3'(BIT_CYC - 1));
    div_d = bit_en ? 3'h0 : 3'(div_q + 1'b1);
    sh_d = sh_q;
    bits_d = bits_q;
    dt_d = dt_q;
    oe_n_d = oe_n_q;
    f_pop = 1'b0;
    // one code leaves per frame sync
    if (fs_rise && pwr_q == PCC_RUN && f_ovalid && bits_q == 4'h0) begin
      f_pop = 1'b1;
      dt_d = f_odata[SIGN_POS];
      sh_d = {f_odata[6:0], 1'b0};
      bits_d = 4'h8;
      oe_n_d = 1'b0;
      div_d = 3'h0;
    end else if (bit_en && bits_q != 4'h0) begin
      bits_d = 4'(bits_q - 1'b1);
      dt_d = sh_q[7];
      sh_d = {sh_q[6:0], 1'b0};
      if (bits_q == 4'h1) begin
        oe_n_d = 1'b1;
      end
    end
    if (pwr_q != PCC_RUN) begin
      oe_n_d = 1'b1;
      bits_d = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 8'h00;
      bits_q <= 4'h0;
      div_q <= 3'h0;
      dt_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      bits_q <= bits_d;
      div_q <= div_d;
      dt_q <= dt_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pcm_transmit_output = dt_q;
  assign pcm_transmit_output_oe_n = oe_n_q;

  // -------------------------------------------------------------
  // decoder
  // -------------------------------------------------------------
  pcc_lin_t out_q, out_d;

  always_comb begin
    out_d.valid = rx_code.valid;
    out_d.sample = out_q.sample;
    // expand received code with shared law
    if (rx_code.valid) begin
      out_d.sample = dec(rx_code.code, mu_sel);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign lin_out = out_q;
endmodule // pcc_codec

// >>> pcc_pkg.sv
package pcc_pkg;
  // -------------------------------------------------------------
  // timing and sizes
  // -------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int BIT_NS = 500;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PU_FRAMES = 2;
  localparam int CODE_W = 8;
  localparam int LIN_W = 13;
  localparam int FIFO_D = 8;

  // -------------------------------------------------------------
  // code layout and law constants
  // -------------------------------------------------------------
  localparam int SIGN_POS = 7;
  localparam int CHORD_POS = 4;
  localparam int STEP_POS = 0;
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [13:0] MU_BIAS_ENC = 14'h0021;
  localparam logic [13:0] MU_CLIP = 14'h1FFF;
  localparam logic [15:0] MU_BIAS_DEC = 16'h0084;
  localparam logic LAW_MU = 1'b1;
  localparam logic [7:0] CODE_RST = 8'hFF;

  typedef struct packed {
    logic valid;
    logic [LIN_W-1:0] sample;
  } pcc_lin_t;

  typedef struct packed {
    logic valid;
    logic [CODE_W-1:0] code;
  } pcc_code_t;

  typedef enum logic [1:0] {PCC_DOWN, PCC_WAKE, PCC_RUN} pcc_pwr_t;
endpackage

// >>> pcc_fifo.sv
`timescale 1ns/1ps
module pcc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d, ir_q, ir_d;
  logic [W-1:0] od_q, od_d;
  logic push, load;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    push = in_valid & ir_q;
    // output register refills whenever it empties or is taken and the memory holds a code
    load = (cnt_q != '0) & (~ov_q | out_ready);
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = load ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push & ~load) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (load & ~push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    ov_d = load | (ov_q & ~out_ready);
    od_d = load ? mem[rp_q] : od_q;
    ir_d = cnt_d < (AW+1)'(D);
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
      ir_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
      ir_q <= ir_d;
    end
  end

  assign in_ready = ir_q;
  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule // pcc_fifo

// >>> pcc_asserts.sv
`timescale 1ns/1ps
module pcc_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // watched pins
  input wire logic power_down_input_n,
  input wire logic transmit_frame_sync,
  input wire logic pcm_transmit_output,
  input wire logic pcm_transmit_output_oe_n,
  input wire pcc_pkg::pcc_code_t rx_code,
  input wire pcc_pkg::pcc_lin_t lin_out
);
  import pcc_pkg::*;
  logic fs_q, fs_d;
  logic [2:0] rise_q, rise_d;
  logic [5:0] low_q, low_d;
  // counts frame rises since power-up, saturating so it cannot wrap
  always_comb begin
    fs_d = transmit_frame_sync;
    rise_d = rise_q;
    low_d = pcm_transmit_output_oe_n ? 6'h00 : low_q + 6'h01;
    if (!power_down_input_n) begin
      rise_d = 3'h0;
    end else if (fs_d && !fs_q && rise_q != 3'h7) begin
      rise_d = rise_q + 3'h1;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fs_q <= 1'b0;
      rise_q <= 3'h0;
      low_q <= 6'h00;
    end else begin
      fs_q <= fs_d;
      rise_q <= rise_d;
      low_q <= low_d;
    end
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_two_down;
    !power_down_input_n ##1 !power_down_input_n;
  endsequence
  sequence s_rx;
    rx_code.valid;
  endsequence
  chk_wake_quiet:
  assert property ($past(power_down_input_n) && rise_q <= 3'h3
    |-> pcm_transmit_output_oe_n)
    else $error("pin driven too soon after power-up");
  chk_down_release:
  assert property (s_two_down |=> pcm_transmit_output_oe_n)
    else $error("pin driven while powered down");
  chk_start_sync:
  assert property ($fell(pcm_transmit_output_oe_n) |->
    $past(transmit_frame_sync) && !$past(transmit_frame_sync, 2))
    else $error("transmit not started by frame sync");
  chk_frame_len:
  assert property ($rose(pcm_transmit_output_oe_n) && $past(power_down_input_n)
    && $past(power_down_input_n, 2) |-> low_q == 6'h28)
    else $error("frame not eight bits of five cycles");
  chk_bit_hold:
  assert property (!pcm_transmit_output_oe_n && (low_q % 6'h05) != 6'h00
    |-> $stable(pcm_transmit_output))
    else $error("serial bit changed inside its cell");
  chk_dec_strobe:
  assert property (s_rx |=> lin_out.valid)
    else $error("no expanded sample after code");
  chk_dec_single:
  assert property (!rx_code.valid |=> !lin_out.valid)
    else $error("expanded sample without code");
  chk_dec_hold:
  assert property (!rx_code.valid |=> $stable(lin_out.sample))
    else $error("expanded sample changed without code");
endmodule // pcc_asserts

bind pcc_codec pcc_asserts chk (
  .mclk(mclk),
  .arst_n(arst_n),
  .power_down_input_n(power_down_input_n),
  .transmit_frame_sync(transmit_frame_sync),
  .pcm_transmit_output(pcm_transmit_output),
  .pcm_transmit_output_oe_n(pcm_transmit_output_oe_n),
  .rx_code(rx_code),
  .lin_out(lin_out)
);

// >>> pcc_highway.sv
`timescale 1ns/1ps
module pcc_highway #(
  parameter int FRAME = 50
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pcm highway
  input wire logic pcm_line,
  input wire logic line_oe_n,
  output logic fs,
  output logic [7:0] got,
  output logic got_v
);
  int fcnt;
  int bcnt;
  logic [7:0] sh;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fcnt <= 0;
      bcnt <= 0;
      fs <= 1'b0;
      sh <= 8'h00;
      got <= 8'h00;
      got_v <= 1'b0;
    end else begin
      fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
      fs <= fcnt < 4;
      got_v <= 1'b0;
      bcnt <= line_oe_n ? 0 : bcnt + 1;
      if (!line_oe_n && bcnt % 5 == 2) begin
        sh <= {sh[6:0], pcm_line};
      end
      if (!line_oe_n && bcnt == 37) begin
        got <= {sh[6:0], pcm_line};
        got_v <= 1'b1;
      end
    end
  end
endmodule // pcc_highway

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import pcc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic law = 1'b1;
  logic pdn = 1'b0;
  pcc_lin_t lin_in = '0;
  pcc_code_t rx_code = '0;
  pcc_lin_t lin_out;
  logic ready, dt, oe_n, fs, got_v;
  logic [7:0] got;
  int n_mismatch = 0;
  int samples_checked = 0;
  // law, sample, code, expanded sample
  logic [34:0] rows [11] = '{
    {1'b1, 13'h0000, 8'hFF, 13'h0000}, {1'b1, 13'h000F, 8'hF0, 13'h000F},
    {1'b1, 13'h0010, 8'hEF, 13'h0010}, {1'b1, 13'h0FFF, 8'h80, 13'h0FAF},
    {1'b1, 13'h1FF7, 8'h77, 13'h1FF8}, {1'b0, 13'h0000, 8'hD5, 13'h0001},
    {1'b0, 13'h001F, 8'hDA, 13'h001F}, {1'b0, 13'h0020, 8'hC5, 13'h0021},
    {1'b0, 13'h0022, 8'hC4, 13'h0023}, {1'b0, 13'h0FFF, 8'hAA, 13'h0FC0},
    {1'b0, 13'h1F9C, 8'h7D, 13'h1F9E}};

  always #50 mclk = ~mclk;

  pcc_codec dut (.mclk(mclk), .arst_n(arst_n), .law_select_pin(law),
    .power_down_input_n(pdn), .transmit_frame_sync(fs), .lin_in(lin_in),
    .lin_in_ready(ready), .pcm_transmit_output(dt),
    .pcm_transmit_output_oe_n(oe_n), .rx_code(rx_code), .lin_out(lin_out));
  // a released line shows the inverted data pin, never its driven level
  pcc_highway hw (.mclk(mclk), .arst_n(arst_n), .pcm_line(dt ^ oe_n),
    .line_oe_n(oe_n), .fs(fs), .got(got), .got_v(got_v));

  task check(input logic [12:0] act, input logic [12:0] exp);
    samples_checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task conclude;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // valid stays up after acceptance; the caller lowers it
  task push(input logic [12:0] s, input int lim, output logic ok);
    int i;
    lin_in = {1'b1, s};
    i = 0;
    while (ready !== 1'b1 && i < lim) begin
      i++;
      @(negedge mclk);
    end
    ok = (ready === 1'b1);
    @(negedge mclk);
  endtask
  task rx(input logic [7:0] c, input logic [12:0] e);
    rx_code = {1'b1, c};
    @(negedge mclk);
    check({12'h000, lin_out.valid}, 13'h0001);
    check(lin_out.sample, e);
  endtask
  task take(input logic [7:0] c);
    int i;
    i = 0;
    while (got_v !== 1'b1 && i < 400) begin
      i++;
      @(negedge mclk);
    end
    if (got_v !== 1'b1) begin
      check({12'h000, got_v}, 13'h0001);
      conclude;
    end else begin
      check({5'h00, got}, {5'h00, c});
      @(negedge mclk);
    end
  endtask

  initial begin
    logic ok;
    int acc;
    repeat (4) @(negedge mclk);
    check({11'h000, ready, oe_n}, 13'h0001);
    $display("reset hold done");
    arst_n = 1'b1;
    pdn = 1'b1;
    foreach (rows[k]) begin
      law = rows[k][34];
      push(rows[k][33:21], 50, ok);
      lin_in.valid = 1'b0;
      check({12'h000, ok}, 13'h0001);
      rx(rows[k][20:13], rows[k][12:0]);
      rx_code.valid = 1'b0;
      take(rows[k][20:13]);
      $display("row %0d done", k);
    end
    // powered down: the buffer fills until it refuses
    law = 1'b1;
    pdn = 1'b0;
    acc = 0;
    for (int k = 0; k < 10; k++) begin
      push(rows[k % 5][33:21], 30, ok);
      acc += ok;
    end
    lin_in.valid = 1'b0;
    check(13'(acc), 13'h0009);
    pdn = 1'b1;
    for (int k = 0; k < 9; k++) begin
      take(rows[k % 5][20:13]);
    end
    $display("buffer test done");
    rx(8'hFF, 13'h0000);
    rx(8'h80, 13'h0FAF);
    rx_code.valid = 1'b0;
    $display("back to back decode done");
    // mid-run reset: data pin was left low, expanded sample non-zero
    arst_n = 1'b0;
    @(negedge mclk);
    check({9'h000, ready, oe_n, dt, lin_out.valid}, 13'h0006);
    check(lin_out.sample, 13'h0000);
    arst_n = 1'b1;
    @(negedge mclk);
    $display("mid-run reset done");
    conclude;
  end
endmodule // testbench
